// ==== logic/dhm_top.v ====
// drive health monitor: history counters, thermal trips, self-test sequencer
`timescale 1ns/1ps
`include "dhm_consts.vh"
module dhm_top #(
   parameter NATTR = 4,
   parameter AW = 2,
   parameter HW = 8,
   parameter TEMP_PERIOD_CYC = 64'd1 * `DHM_TEMP_PERIOD_S * `DHM_CLK_HZ,
   parameter SHORT_LIMIT_CYC = 64'd1 * `DHM_SHORT_LIMIT_S * `DHM_CLK_HZ
) (
   input wire clk_i,
   input wire rst_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   input wire wb_we_i,
   input wire [3:0] wb_sel_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg wb_ack_o,
   input wire [NATTR-1:0] interval_end_i,
   input wire [NATTR-1:0] rate_bad_i,
   input wire [7:0] temp_i,
   input wire motor_spin_fail_i,
   input wire motor_lock_fail_i,
   input wire servo_lock_fail_i,
   input wire config_read_fail_i,
   input wire diag_start_i,
   input wire [7:0] diag_byte1_i,
   input wire seg_done_i,
   input wire scan_done_i,
   input wire op_error_i,
   input wire retries_exhausted_i,
   input wire tur_i,
   output wire not_ready_o,
   output reg tur_done_o,
   output reg [23:0] tur_sense_o,
   output reg pf_event_o,
   output reg [AW-1:0] pf_attr_o,
   output reg temp_event_o,
   output reg [23:0] temp_sense_o,
   output reg [7:0] replaceable_unit_code_o,
   output reg [3:0] temp_method_o,
   output reg frame_save_o,
   output reg round_event_o,
   output reg [23:0] round_sense_o,
   output reg test_done_o,
   output reg [3:0] test_result_o,
   output reg [2:0] test_func_o,
   output reg diag_refused_o,
   output reg [1:0] test_segment_o,
   output wire test_busy_o,
   output wire full_scan_o,
   output wire write_path_o,
   output wire retries_enabled_o
);
   localparam S_IDLE = 2'h0;
   localparam S_ELEC = 2'h1;
   localparam S_SERVO = 2'h2;
   localparam S_SCAN = 2'h3;
   localparam [7:0] TEMP_MAX = `DHM_FIXED_TRIP;
   // control / state registers
   reg warning_enable_bit;
   reg [3:0] exception_report_method;
   reg [7:0] ref_temp;
   reg [HW-1:0] pf_thresh;
   reg [15:0] ext_time;
   reg [7:0] cur_temp;
   reg [NATTR-1:0] pf_flag;
   reg [39:0] temp_cnt;
   reg first_sample;
   reg [1:0] state;
   reg [2:0] func;
   reg [39:0] test_cnt;
   reg hist_wait;
   wire hist_sel;
   reg [3:0] last_result;
   reg [AW-1:0] scan_idx;
   wire [AW-1:0] hist_raddr;
   wire [HW-1:0] hist_rdata;
   // per-attribute update
   wire upd_any;
   reg [AW-1:0] upd_idx;
   reg [HW-1:0] hist_cur [0:NATTR-1];
   reg [HW-1:0] next_hist;
   integer i;
   assign retries_enabled_o = 1'b1;
   assign not_ready_o = motor_spin_fail_i | motor_lock_fail_i
      | servo_lock_fail_i | config_read_fail_i;
   assign test_busy_o = (state != S_IDLE);
   assign full_scan_o = (state == S_SCAN) && (func == `DHM_FC_EXTENDED);
   assign write_path_o = full_scan_o;
   // history counter shadow: one per attribute, updated only by its own interval end
   genvar g;
   generate
      for (g = 0; g < NATTR; g = g + 1) begin : g_attr
         always @(posedge clk_i) begin
            if (rst_i) begin
               hist_cur[g] <= {HW{1'b0}};
               pf_flag[g] <= 1'b0;
            end else if (interval_end_i[g]) begin
               if (rate_bad_i[g]) begin
                  if (hist_cur[g] != {HW{1'b1}}) begin
                     hist_cur[g] <= hist_cur[g] + 1'b1;
                  end
               end else if (hist_cur[g] != {HW{1'b0}}) begin
                  hist_cur[g] <= hist_cur[g] - 1'b1;
               end
               pf_flag[g] <= rate_bad_i[g] && (hist_cur[g] + 1'b1 >= pf_thresh);
            end else begin
               pf_flag[g] <= 1'b0;
            end
         end
      end
   endgenerate
   // copy into memory for software reads, one attribute per cycle in turn at scan_idx
   assign upd_any = |interval_end_i;
   always @* begin
      upd_idx = {AW{1'b0}};
      for (i = NATTR - 1; i >= 0; i = i - 1) begin
         if (interval_end_i[i]) begin
            upd_idx = i[AW-1:0];
         end
      end
      next_hist = hist_cur[scan_idx];
   end
   assign hist_raddr = wb_adr_i[AW+1:2];
   assign hist_sel = (wb_adr_i[7:5] == 3'h1);
   dhm_hist_mem #(.NATTR(NATTR), .AW(AW), .W(HW)) u_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(1'b1),
      .waddr_i(scan_idx),
      .wdata_i(next_hist),
      .raddr_i(hist_raddr),
      .rdata_o(hist_rdata)
   );
   // predictive failure pulse
   always @(posedge clk_i) begin
      if (rst_i) begin
         scan_idx <= {AW{1'b0}};
         pf_event_o <= 1'b0;
         pf_attr_o <= {AW{1'b0}};
      end else begin
         scan_idx <= scan_idx + 1'b1;
         pf_event_o <= |pf_flag;
         for (i = NATTR - 1; i >= 0; i = i - 1) begin
            if (pf_flag[i]) begin
               pf_attr_o <= i[AW-1:0];
            end
         end
      end
   end
   // thermal monitor
   always @(posedge clk_i) begin
      if (rst_i) begin
         temp_cnt <= 40'h0000000000;
         first_sample <= 1'b1;
         cur_temp <= 8'h00;
         temp_event_o <= 1'b0;
         frame_save_o <= 1'b0;
         temp_sense_o <= 24'h000000;
         replaceable_unit_code_o <= 8'h00;
         temp_method_o <= 4'h0;
      end else begin
         temp_event_o <= 1'b0;
         frame_save_o <= 1'b0;
         if (first_sample || temp_cnt == TEMP_PERIOD_CYC - 1) begin
            first_sample <= 1'b0;
            temp_cnt <= 40'h0000000000;
            cur_temp <= temp_i;
            frame_save_o <= (temp_i > TEMP_MAX);
            if (warning_enable_bit && (temp_i > TEMP_MAX || temp_i > ref_temp)) begin
               temp_event_o <= 1'b1;
               temp_sense_o <= `DHM_SENSE_TEMP;
               replaceable_unit_code_o <= temp_i;
               temp_method_o <= exception_report_method;
            end
         end else begin
            temp_cnt <= temp_cnt + 1'b1;
         end
      end
   end
   // test unit ready answer
   always @(posedge clk_i) begin
      if (rst_i) begin
         tur_done_o <= 1'b0;
         tur_sense_o <= 24'h000000;
      end else begin
         tur_done_o <= tur_i;
         if (tur_i) begin
            if (config_read_fail_i) begin
               tur_sense_o <= `DHM_SENSE_NR_INIT;
            end else if (not_ready_o) begin
               tur_sense_o <= `DHM_SENSE_NR_CAUSE;
            end else begin
               tur_sense_o <= 24'h000000;
            end
         end
      end
   end
   // self-test sequencer
   always @(posedge clk_i) begin
      if (rst_i) begin
         state <= S_IDLE;
         func <= 3'h0;
         test_cnt <= 40'h0000000000;
         last_result <= `DHM_RES_PASS;
         test_done_o <= 1'b0;
         test_result_o <= `DHM_RES_PASS;
         test_func_o <= 3'h0;
         diag_refused_o <= 1'b0;
         test_segment_o <= S_IDLE;
      end else begin
         test_done_o <= 1'b0;
         diag_refused_o <= 1'b0;
         case (state)
            S_IDLE: begin
               if (diag_start_i) begin
                  if (not_ready_o) begin
                     diag_refused_o <= 1'b1;
                  end else if (diag_byte1_i[`DHM_FC_HI:`DHM_FC_LO] == `DHM_FC_SHORT ||
                     diag_byte1_i[`DHM_FC_HI:`DHM_FC_LO] == `DHM_FC_EXTENDED) begin
                     func <= diag_byte1_i[`DHM_FC_HI:`DHM_FC_LO];
                     state <= S_ELEC;
                     test_cnt <= 40'h0000000000;
                     last_result <= `DHM_RES_RUNNING;
                  end else begin
                     diag_refused_o <= 1'b1;
                  end
               end
            end
            default: begin
               test_cnt <= test_cnt + 1'b1;
               if (op_error_i && retries_exhausted_i) begin
                  state <= S_IDLE;
                  last_result <= `DHM_RES_FAILED;
                  test_done_o <= 1'b1;
                  test_result_o <= `DHM_RES_FAILED;
                  test_func_o <= func;
               end else if ((state == S_SCAN && scan_done_i) ||
                  (func == `DHM_FC_SHORT && test_cnt == SHORT_LIMIT_CYC - 1)) begin
                  state <= S_IDLE;
                  last_result <= `DHM_RES_PASS;
                  test_done_o <= 1'b1;
                  test_result_o <= `DHM_RES_PASS;
                  test_func_o <= func;
               end else if (seg_done_i && state != S_SCAN) begin
                  state <= state + 2'h1;
               end
            end
         endcase
         test_segment_o <= state;
      end
   end
   // wishbone slave, one wait state, two for any access (read or write) to the history window
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         hist_wait <= 1'b0;
         wb_dat_o <= 32'h00000000;
         warning_enable_bit <= 1'b0;
         exception_report_method <= `DHM_EXCEPTION_REPORT_METHOD_RESET;
         ref_temp <= `DHM_REF_RESET;
         pf_thresh <= `DHM_THRESH_RESET;
         ext_time <= `DHM_XTIME_RESET;
         round_event_o <= 1'b0;
         round_sense_o <= 24'h000000;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o & (~hist_sel | hist_wait);
         hist_wait <= wb_cyc_i & wb_stb_i & ~wb_ack_o & hist_sel & ~hist_wait;
         round_event_o <= 1'b0;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i) begin
            case (wb_adr_i)
               `DHM_ADR_CTRL: begin
                  if (wb_sel_i[0]) begin
                     warning_enable_bit <= wb_dat_i[`DHM_CTRL_WEN];
                     exception_report_method <= wb_dat_i[`DHM_CTRL_EXCEPTION_REPORT_METHOD_HI:`DHM_CTRL_EXCEPTION_REPORT_METHOD_LO];
                  end
               end
               `DHM_ADR_REFTEMP: begin
                  if (wb_sel_i[0]) begin
                     if (wb_dat_i[7:0] > TEMP_MAX) begin
                        ref_temp <= TEMP_MAX;
                        round_event_o <= 1'b1;
                        round_sense_o <= `DHM_SENSE_ROUND;
                     end else begin
                        ref_temp <= wb_dat_i[7:0];
                     end
                  end
               end
               `DHM_ADR_THRESH: begin
                  if (wb_sel_i[0]) begin
                     pf_thresh <= wb_dat_i[HW-1:0];
                  end
               end
               `DHM_ADR_XTIME: begin
                  if (wb_sel_i[0]) begin
                     ext_time[7:0] <= wb_dat_i[7:0];
                  end
                  if (wb_sel_i[1]) begin
                     ext_time[15:8] <= wb_dat_i[15:8];
                  end
               end
               default: begin
               end
            endcase
         end
         if (wb_adr_i[7:5] == 3'h1) begin
            wb_dat_o <= {{(32-HW){1'b0}}, hist_rdata};
         end else begin
            case (wb_adr_i)
               `DHM_ADR_CTRL: wb_dat_o <= {27'h0000000, exception_report_method, warning_enable_bit};
               `DHM_ADR_STATUS: wb_dat_o <= {20'h00000, last_result, 1'b0, not_ready_o, state, 4'h0};
               `DHM_ADR_REFTEMP: wb_dat_o <= {24'h000000, ref_temp};
               `DHM_ADR_CURTEMP: wb_dat_o <= {24'h000000, cur_temp};
               `DHM_ADR_THRESH: wb_dat_o <= {{(32-HW){1'b0}}, pf_thresh};
               `DHM_ADR_XTIME: wb_dat_o <= {16'h0000, ext_time};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule

// ==== logic/dhm_consts.vh ====
// constants of the drive health monitor
`ifndef DHM_CONSTS_VH
`define DHM_CONSTS_VH
`define DHM_ADR_CTRL 8'h00
`define DHM_ADR_STATUS 8'h04
`define DHM_ADR_REFTEMP 8'h08
`define DHM_ADR_CURTEMP 8'h0C
`define DHM_ADR_THRESH 8'h10
`define DHM_ADR_HIST 8'h14
`define DHM_ADR_DIAG 8'h18
`define DHM_ADR_XTIME 8'h1C
`define DHM_CTRL_WEN 0
`define DHM_CTRL_EXCEPTION_REPORT_METHOD_LO 1
`define DHM_CTRL_EXCEPTION_REPORT_METHOD_HI 4
`define DHM_FIXED_TRIP 8'h41
`define DHM_REF_RESET 8'h41
`define DHM_THRESH_RESET 8'h08
`define DHM_EXCEPTION_REPORT_METHOD_RESET 4'h0
`define DHM_XTIME_RESET 16'h0000
`define DHM_SENSE_TEMP 24'h010B01
`define DHM_SENSE_ROUND 24'h013700
`define DHM_SENSE_NR_CAUSE 24'h020400
`define DHM_SENSE_NR_INIT 24'h020403
`define DHM_LOG_PAGE_TEMP 8'h0D
`define DHM_PARAM_PRIMARY 16'h0000
`define DHM_PARAM_REFERENCE 16'h0001
`define DHM_FC_SHORT 3'h1
`define DHM_FC_EXTENDED 3'h2
`define DHM_FC_LO 5
`define DHM_FC_HI 7
`define DHM_RES_PASS 4'h0
`define DHM_RES_FAILED 4'h7
`define DHM_RES_RUNNING 4'hF
`define DHM_TEMP_PERIOD_S 600
`define DHM_SHORT_LIMIT_S 120
`define DHM_CLK_HZ 40000000
`endif

// ==== logic/dhm_hist_mem.v ====
// per-attribute failure history counter memory
`timescale 1ns/1ps
module dhm_hist_mem #(
   parameter NATTR = 4,
   parameter AW = 2,
   parameter W = 8
) (
   input wire clk_i,
   input wire rst_i,
   input wire we_i,
   input wire [AW-1:0] waddr_i,
   input wire [W-1:0] wdata_i,
   input wire [AW-1:0] raddr_i,
   output reg [W-1:0] rdata_o
);
   reg [W-1:0] mem [0:NATTR-1];
   integer k;
   always @(posedge clk_i) begin
      if (rst_i) begin
         for (k = 0; k < NATTR; k = k + 1) begin
            mem[k] <= {W{1'b0}};
         end
         rdata_o <= {W{1'b0}};
      end else begin
         if (we_i) begin
            mem[waddr_i] <= wdata_i;
         end
         rdata_o <= mem[raddr_i];
      end
   end
endmodule

// ==== dv/dhm_top_props.sv ====
// port assertions for the health monitor
`timescale 1ns/1ps
module dhm_top_props (
   input wire clk_i,
   input wire rst_i,
   input wire motor_spin_fail_i,
   input wire motor_lock_fail_i,
   input wire servo_lock_fail_i,
   input wire config_read_fail_i,
   input wire not_ready_o,
   input wire tur_i,
   input wire tur_done_o,
   input wire [23:0] tur_sense_o,
   input wire diag_start_i,
   input wire [7:0] diag_byte1_i,
   input wire diag_refused_o,
   input wire [1:0] test_segment_o,
   input wire test_busy_o,
   input wire op_error_i,
   input wire retries_exhausted_i,
   input wire test_done_o,
   input wire [3:0] test_result_o,
   input wire temp_event_o,
   input wire [23:0] temp_sense_o,
   input wire full_scan_o,
   input wire retries_enabled_o
);
   wire [2:0] fc = diag_byte1_i[7:5];
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_ask;
      diag_start_i && test_segment_o == 2'h0;
   endsequence
   sequence s_ok;
      !not_ready_o && (fc == 3'h1 || fc == 3'h2);
   endsequence
   chk_nr_cause: assert property (not_ready_o == (motor_spin_fail_i | motor_lock_fail_i |
      servo_lock_fail_i | config_read_fail_i)) else $error("not ready cause");
   chk_tur_code: assert property (tur_i |=> tur_done_o && tur_sense_o ==
      ($past(config_read_fail_i) ? 24'h020403 : $past(not_ready_o) ? 24'h020400 : 24'h000000))
      else $error("tur sense");
   chk_start_refused: assert property (s_ask ##0 not_ready_o |=> diag_refused_o && test_segment_o == 2'h0)
      else $error("start not refused");
   chk_start_elec: assert property (s_ask ##0 s_ok |=> !diag_refused_o ##1 test_segment_o == 2'h1)
      else $error("no electrical segment");
   chk_bad_code: assert property (s_ask ##0 !(fc == 3'h1 || fc == 3'h2) |=> diag_refused_o)
      else $error("bad code taken");
   chk_fail_exh: assert property (test_busy_o && op_error_i && retries_exhausted_i |=>
      test_done_o && test_result_o == 4'h7) else $error("no fail result");
   chk_recovered_ok: assert property (test_busy_o && op_error_i && !retries_exhausted_i |=>
      !(test_done_o && test_result_o == 4'h7)) else $error("recovered error failed");
   chk_temp_code: assert property (temp_event_o |-> temp_sense_o == 24'h010B01)
      else $error("temp sense");
   chk_scan_seg: assert property (full_scan_o |=> test_segment_o == 2'h3)
      else $error("full scan outside scan");
   chk_done_pulse: assert property (test_done_o |=> !test_done_o && test_segment_o == 2'h0)
      else $error("done not a pulse");
   chk_retry_on: assert property (retries_enabled_o)
      else $error("retries off");
endmodule
bind dhm_top dhm_top_props dhm_top_props_inst (.clk_i(clk_i), .rst_i(rst_i),
   .motor_spin_fail_i(motor_spin_fail_i), .motor_lock_fail_i(motor_lock_fail_i),
   .servo_lock_fail_i(servo_lock_fail_i), .config_read_fail_i(config_read_fail_i),
   .not_ready_o(not_ready_o), .tur_i(tur_i), .tur_done_o(tur_done_o), .tur_sense_o(tur_sense_o),
   .diag_start_i(diag_start_i), .diag_byte1_i(diag_byte1_i), .diag_refused_o(diag_refused_o),
   .test_segment_o(test_segment_o), .test_busy_o(test_busy_o), .op_error_i(op_error_i),
   .retries_exhausted_i(retries_exhausted_i), .test_done_o(test_done_o), .test_result_o(test_result_o),
   .temp_event_o(temp_event_o), .temp_sense_o(temp_sense_o), .full_scan_o(full_scan_o),
   .retries_enabled_o(retries_enabled_o));

// ==== dv/dhm_host_model.sv ====
// host controller model issuing test commands
`timescale 1ns/1ps
module dhm_host_model (
   input wire clk_i,
   output logic tur_o,
   output logic diag_start_o,
   output logic [7:0] diag_byte1_o,
   output logic [3:0] step_o
);
   initial begin
      tur_o = 1'b0;
      diag_start_o = 1'b0;
      diag_byte1_o = 8'h00;
      step_o = 4'h0;
   end
   task tur;
      @(posedge clk_i) tur_o <= 1'b1;
      @(posedge clk_i) tur_o <= 1'b0;
   endtask
   task diag(input logic [2:0] fc);
      @(posedge clk_i) diag_start_o <= 1'b1;
      diag_byte1_o <= {fc, 5'h00};
      @(posedge clk_i) diag_start_o <= 1'b0;
      diag_byte1_o <= ~diag_byte1_o;
   endtask
   task ready_diag(input logic [2:0] fc);
      tur();
      diag(fc);
   endtask
   task step(input logic [3:0] k);
      repeat ($urandom % 5) @(posedge clk_i);
      @(posedge clk_i) step_o <= k;
      @(posedge clk_i) step_o <= 4'h0;
   endtask
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the health monitor
`timescale 1ns/1ps
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00, temp = 8'h14, db, ruc;
   logic [31:0] wdat = 32'h0, rdat, wbo, q[$];
   logic [3:0] ie = 4'h0, bad = 4'h0, fails = 4'h0, tm, res, stp;
   logic [23:0] ts, tsn, rsn;
   logic [2:0] fn;
   logic [1:0] pfa, a;
   logic ack, nr, td, pfe, te, re, dn, rf, fs, wp, tur, ds, fsv;
   int num_errors = 0, comparisons = 0, events = 0, frames = 0;
   dhm_host_model dhm_host_model_inst (.clk_i(clk_i), .tur_o(tur), .diag_start_o(ds), .diag_byte1_o(db),
      .step_o(stp));
   dhm_top #(.TEMP_PERIOD_CYC(100), .SHORT_LIMIT_CYC(200)) dhm_top_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(wbo), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_ack_o(ack), .interval_end_i(ie), .rate_bad_i(bad), .temp_i(temp),
      .motor_spin_fail_i(fails[0]), .motor_lock_fail_i(fails[1]), .servo_lock_fail_i(fails[2]),
      .config_read_fail_i(fails[3]), .diag_start_i(ds), .diag_byte1_i(db), .seg_done_i(stp[3]),
      .scan_done_i(stp[2]), .op_error_i(stp[1]), .retries_exhausted_i(stp[0]), .tur_i(tur),
      .not_ready_o(nr), .tur_done_o(td), .tur_sense_o(ts), .pf_event_o(pfe), .pf_attr_o(pfa),
      .temp_event_o(te), .temp_sense_o(tsn), .replaceable_unit_code_o(ruc), .temp_method_o(tm),
      .frame_save_o(fsv), .round_event_o(re), .round_sense_o(rsn), .test_done_o(dn), .test_result_o(res),
      .test_func_o(fn), .diag_refused_o(rf), .test_segment_o(), .test_busy_o(), .full_scan_o(fs),
      .write_path_o(wp), .retries_enabled_o());
   initial forever #12.5 clk_i = ~clk_i;
   task end_sim;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task note(input logic [31:0] seen);
      events++;
      check(seen, q.size() > 0 ? q.pop_front() : 32'hDEADBEEF);
   endtask
   // monitor: every result pulse but the frame save takes the oldest expectation; frame saves are only counted
   always @(posedge clk_i) begin
      if (!rst_i && te) note({16'h1000, tm, ruc, 4'h0});
      if (!rst_i && te) check({8'h00, tsn}, 32'h00010B01);
      if (!rst_i && fsv) frames++;
      if (!rst_i && pfe) note({30'h2, pfa});
      if (!rst_i && re) note({8'h03, rsn});
      if (!rst_i && td) note({8'h04, ts});
      if (!rst_i && rf) note(32'h5);
      if (!rst_i && dn) note({21'h6, fn, 4'h0, res});
   end
   task wait_ev(input int lim);
      int n0, n;
      n0 = events;
      for (n = 0; n < lim && events == n0; n++) @(posedge clk_i);
      if (events == n0) check(32'h0, 32'h1);
   endtask
   task wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rdat = wbo;
      if (n >= 50) num_errors++;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task wr(input logic [7:0] ad, input logic [31:0] d);
      wb(1'b1, ad, d);
   endtask
   task rd(input logic [7:0] ad, input logic [31:0] exp);
      wb(1'b0, ad, 32'h0);
      check(rdat, exp);
   endtask
   task iv(input logic [3:0] m, input logic [3:0] b);
      @(posedge clk_i);
      ie <= m;
      bad <= b;
      @(posedge clk_i);
      ie <= 4'h0;
      bad <= ~b;
   endtask
   task tev(input logic [7:0] t, input logic [3:0] m);
      temp <= t;
      q.push_back({16'h1000, m, t, 4'h0});
      wait_ev(150);
      temp <= 8'h14;
   endtask
   task dg(input logic [2:0] c);
      dhm_host_model_inst.diag(c);
   endtask
   task st(input logic [3:0] k);
      dhm_host_model_inst.step(k);
   endtask
   initial begin
      void'($urandom(17));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h10, 32'h8);
      rd(8'h08, 32'h41);
      rd(8'hF0, 32'h0);
      wr(8'h00, 32'hD);
      q.push_back({8'h03, 24'h013700});
      wr(8'h08, 32'h42 + ($urandom % 190));
      rd(8'h08, 32'h41);
      wr(8'h08, 32'h28);
      tev(8'h32, 4'h6);
      wr(8'h08, 32'h41);
      tev(8'h46, 4'h6);
      wr(8'h00, 32'h3);
      tev(8'h42, 4'h1);
      wr(8'h00, 32'h2);
      temp <= 8'h50;
      repeat (100) @(posedge clk_i);
      temp <= 8'h14;
      rd(8'h0C, 32'h50);
      a = 2'($urandom % 4);
      wr(8'h10, 32'h2);
      iv(4'h1 << (a + 2'h1), 4'h0);
      iv(4'h1 << a, 4'hF);
      q.push_back({30'h2, a});
      iv(4'h1 << a, 4'hF);
      wait_ev(10);
      repeat (8) @(posedge clk_i);
      rd(8'h20 + {4'h0, a, 2'h0}, 32'h2);
      rd(8'h20 + {4'h0, a + 2'h1, 2'h0}, 32'h0);
      iv(4'h1 << a, 4'h0);
      repeat (8) @(posedge clk_i);
      rd(8'h20 + {4'h0, a, 2'h0}, 32'h1);
      q.push_back({8'h04, 24'h0});
      q.push_back({21'h6, 3'h2, 8'h00});
      dhm_host_model_inst.ready_diag(3'h2);
      st(4'h8);
      st(4'h8);
      @(negedge clk_i);
      check({30'h0, fs, wp}, 32'h3);
      st(4'h2);
      st(4'h4);
      wait_ev(5);
      q.push_back({21'h6, 3'h1, 8'h07});
      dg(3'h1);
      st(4'h8);
      st(4'h3);
      wait_ev(5);
      q.push_back({21'h6, 3'h1, 8'h00});
      dg(3'h1);
      wait_ev(260);
      for (int c = 0; c < 8; c++) if (c != 1 && c != 2) begin
         q.push_back(32'h5);
         dg(3'(c));
         wait_ev(5);
      end
      for (int i = 0; i < 4; i++) begin
         fails <= 4'h1 << i;
         q.push_back({8'h04, i == 3 ? 24'h020403 : 24'h020400});
         dhm_host_model_inst.tur();
         check({31'h0, nr}, 32'h1);
         wait_ev(5);
         q.push_back(32'h5);
         dg(3'h1);
         wait_ev(5);
      end
      fails <= 4'h0;
      check(32'(q.size()), 32'h0);
      check(32'(frames), 32'h3);
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      end_sim;
   end
endmodule
